//--- core/cpu_ctl_regs.sv
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`default_nettype none
module cpu_ctl_regs
    import cpu_ctl_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    // axi4-lite slave
    input  wire logic [7:0]  S_AWADDR,
    input  wire logic        S_AWVALID,
    output logic             S_AWREADY,
    input  wire logic [31:0] S_WDATA,
    input  wire logic [3:0]  S_WSTRB,
    input  wire logic        S_WVALID,
    output logic             S_WREADY,
    output logic [1:0]       S_BRESP,
    output logic             S_BVALID,
    input  wire logic        S_BREADY,
    input  wire logic [7:0]  S_ARADDR,
    input  wire logic        S_ARVALID,
    output logic             S_ARREADY,
    output logic [31:0]      S_RDATA,
    output logic [1:0]       S_RRESP,
    output logic             S_RVALID,
    input  wire logic        S_RREADY,
    // core events
    input  wire logic        FETCH_ADV,
    input  wire logic [1:0]  FETCH_LEN,
    input  wire logic        BRANCH,
    input  wire logic [15:0] BRANCH_TARGET,
    input  wire logic        IRQ_ACK,
    input  wire logic [5:0]  IRQ_VECTOR,
    input  wire logic        IRQ_LOW_LEVEL,
    input  wire logic        IRQ_ENABLE_INSTR,
    input  wire logic        IRQ_DISABLE_INSTR,
    input  wire logic        ALU_WE,
    input  wire logic        ALU_SUB,
    input  wire logic [7:0]  ALU_A,
    input  wire logic [7:0]  ALU_B,
    input  wire logic        CARRY_WE,
    input  wire logic        CARRY_IN,
    input  wire logic        BANK_SELECT_INSTR,
    input  wire logic [1:0]  BANK_SELECT,
    input  wire logic        STATE_RESTORE,
    input  wire logic [7:0]  STATE_RESTORE_DATA,
    input  wire logic        STACK_PUSH,
    input  wire logic        STACK_POP,
    input  wire logic [15:0] MEM_ADDR,
    input  wire logic        MEM_FETCH,
    input  wire logic [7:0]  VEC_DATA,
    // outputs to the core
    output logic [15:0]      NEXT_FETCH_POINTER,
    output logic [7:0]       PROCESSOR_STATE_WORD,
    output logic [15:0]      STACK_TOP_POINTER,
    output logic [15:0]      STACK_ADDR,
    output logic [7:0]       MEMORY_SIZE_SELECT,
    output logic             VEC_RD,
    output logic [15:0]      VEC_ADDR,
    output logic             CORE_RUN,
    output logic [3:0]       MEM_REGION,
    output logic             FETCH_FAULT,
    output logic             IRQ_ALLOW
);
    // ********************************************
    // state
    // ********************************************
    typedef struct packed {
        vstate_t      st;
        logic [7:0]   vlo;
        logic [15:0]  pc;
        logic [7:0]   processor_state_word;
        logic [15:0]  sp;
        logic         sp_set;
        logic [7:0]   memory_size_select;
        logic [15:0]  stk_addr;
        logic         vec_rd;
        logic [15:0]  vec_addr;
        logic [3:0]   region;
        logic         fetch_fault;
        logic         irq_allow;
        logic         awrdy;
        logic [7:0]   awaddr;
        logic         wrdy;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         arrdy;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [3:0]  region_now;
    logic [8:0]  sum9;
    logic [4:0]  sum5;
    logic [15:0] wr16;

    // byte lanes 0 and 1 carry the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction : merge16

    map_decode u_map (
        .addr     (MEM_ADDR),
        .mem_size (s_q.memory_size_select),
        .region   (region_now)
    );

    // ********************************************
    // next state
    // ********************************************
    always_comb begin
        s_d  = s_q;
        wr16 = merge16(16'h0000, s_q.wdata, s_q.wstrb);
        sum9 = 9'h000;
        sum5 = 5'h00;

        // axi address and data channels, taken in either order
        if (s_q.awrdy && S_AWVALID) begin
            s_d.awrdy  = 1'b0;
            s_d.awaddr = S_AWADDR;
        end
        if (s_q.wrdy && S_WVALID) begin
            s_d.wrdy  = 1'b0;
            s_d.wdata = S_WDATA;
            s_d.wstrb = S_WSTRB;
        end
        // write performed once both halves are held
        if (!s_q.awrdy && !s_q.wrdy && !s_q.bvalid) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            case (s_q.awaddr)
                OFS_FETCH_PTR: begin
                    // a write acts as a branch; ignored during vector fetch
                    if (s_q.st == ST_RUN) begin
                        s_d.pc = merge16(s_q.pc, s_q.wdata, s_q.wstrb);
                    end
                end
                OFS_STATE_WORD: begin
                    if (s_q.wstrb[0]) begin
                        s_d.processor_state_word = s_q.wdata[7:0];
                    end
                end
                OFS_STACK_PTR: begin
                    wr16 = merge16(s_q.sp, s_q.wdata, s_q.wstrb);
                    // only RAM may hold the stack
                    if (wr16 >= RAM_FIRST && wr16 <= RAM_LAST) begin
                        s_d.sp     = wr16;
                        s_d.sp_set = 1'b1;
                    end else begin
                        s_d.bresp = RESP_SLVERR;
                    end
                end
                OFS_MEM_SIZE: begin
                    if (s_q.wstrb[0]) begin
                        s_d.memory_size_select = s_q.wdata[7:0];
                    end
                end
                OFS_STATUS: begin
                    s_d.bresp = RESP_OKAY;  // read-only, write dropped
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && S_BREADY) begin
            s_d.bvalid = 1'b0;
            s_d.awrdy  = 1'b1;
            s_d.wrdy   = 1'b1;
        end

        // read channel, answer one cycle after address taken
        if (s_q.arrdy && S_ARVALID) begin
            s_d.arrdy  = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            case (S_ARADDR)
                OFS_FETCH_PTR:  s_d.rdata = {16'h0000, s_q.pc};
                OFS_STATE_WORD: s_d.rdata = {24'h000000, s_q.processor_state_word};
                OFS_STACK_PTR:  s_d.rdata = {16'h0000, s_q.sp};
                OFS_MEM_SIZE:   s_d.rdata = {24'h000000, s_q.memory_size_select};
                OFS_STATUS:     s_d.rdata = {27'h0000000, s_q.st, s_q.sp_set};
                default: begin
                    s_d.rdata = 32'h00000000;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && S_RREADY) begin
            s_d.rvalid = 1'b0;
            s_d.arrdy  = 1'b1;
        end

        // instruction fetch from RAM is flagged; peripheral area is not
        s_d.region      = region_now;
        s_d.fetch_fault = MEM_FETCH && (region_now == RG_RAM || region_now == RG_BANKS);

        // ********************************************
        // vector fetch sequencer
        // ********************************************
        case (s_q.st)
            ST_VLO: begin
                // high byte read from the odd address next
                s_d.vec_addr = s_q.vec_addr | 16'h0001;
                s_d.vec_rd   = 1'b1;
                s_d.st       = ST_VHI;
            end
            ST_VHI: begin
                s_d.vlo    = VEC_DATA;
                s_d.vec_rd = 1'b0;
                s_d.st     = ST_VEND;
            end
            ST_VEND: begin
                // fetch pointer loaded from vector bytes
                s_d.pc = {VEC_DATA, s_q.vlo};
                s_d.st = ST_RUN;
            end
            ST_RUN: begin
                if (BRANCH) begin
                    s_d.pc = BRANCH_TARGET;
                end else if (FETCH_ADV) begin
                    s_d.pc = s_q.pc + {14'h0000, FETCH_LEN};
                end
                // enable sets, disable wins over enable
                if (IRQ_ENABLE_INSTR) begin
                    s_d.processor_state_word[PSW_GATE] = 1'b1;
                end
                if (IRQ_DISABLE_INSTR) begin
                    s_d.processor_state_word[PSW_GATE] = 1'b0;
                end
                // restore from stack by return or pop
                if (STATE_RESTORE) begin
                    s_d.processor_state_word = STATE_RESTORE_DATA;
                end
                // nibble carry or borrow at bit 3
                if (ALU_WE) begin
                    sum9 = ALU_SUB ? ({1'b0, ALU_A} - {1'b0, ALU_B})
                                   : ({1'b0, ALU_A} + {1'b0, ALU_B});
                    sum5 = ALU_SUB ? ({1'b0, ALU_A[3:0]} - {1'b0, ALU_B[3:0]})
                                   : ({1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]});
                    s_d.processor_state_word[PSW_ZERO]  = (sum9[7:0] == 8'h00);
                    s_d.processor_state_word[PSW_NIBBL] = sum5[4];
                    s_d.processor_state_word[PSW_CARRY] = sum9[8];
                end
                if (CARRY_WE) begin
                    s_d.processor_state_word[PSW_CARRY] = CARRY_IN;
                end
                if (BANK_SELECT_INSTR) begin
                    s_d.processor_state_word[PSW_BANK0] = BANK_SELECT[0];
                    s_d.processor_state_word[PSW_BANK1] = BANK_SELECT[1];
                end
                // decrement before write, increment after read
                if (STACK_PUSH) begin
                    s_d.sp       = s_q.sp - 16'h0001;
                    s_d.stk_addr = s_q.sp - 16'h0001;
                end else if (STACK_POP) begin
                    s_d.sp       = s_q.sp + 16'h0001;
                    s_d.stk_addr = s_q.sp;
                end
                // acknowledge clears gate, fetches source slot
                if (IRQ_ACK) begin
                    s_d.processor_state_word[PSW_GATE] = 1'b0;
                    s_d.vec_addr      = {10'h000, IRQ_VECTOR[5:1], 1'b0};
                    s_d.vec_rd        = 1'b1;
                    s_d.st            = ST_VLO;
                end
            end
            default: begin
                s_d.st = ST_RUN;
            end
        endcase

        // gate off blocks all; low level blocked when level flag clear
        s_d.irq_allow = s_d.processor_state_word[PSW_GATE] && (s_d.st == ST_RUN) &&
                        (s_d.processor_state_word[PSW_LEVEL] || !IRQ_LOW_LEVEL);
    end

    // ********************************************
    // registers
    // ********************************************
    // 02H via level flag at bit 1; size CFH; stack unset
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q             <= '0;
            s_q.st          <= ST_VLO;
            s_q.processor_state_word         <= RST_STATE_WORD;
            s_q.memory_size_select         <= RST_MEM_SIZE;
            s_q.sp          <= RST_STACK_PTR;
            s_q.vec_rd      <= 1'b1;
            s_q.vec_addr    <= VEC_RESET;
            s_q.awrdy       <= 1'b1;
            s_q.wrdy        <= 1'b1;
            s_q.arrdy       <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign S_AWREADY            = s_q.awrdy;
    assign S_WREADY             = s_q.wrdy;
    assign S_BVALID             = s_q.bvalid;
    assign S_BRESP              = s_q.bresp;
    assign S_ARREADY            = s_q.arrdy;
    assign S_RVALID             = s_q.rvalid;
    assign S_RDATA              = s_q.rdata;
    assign S_RRESP              = s_q.rresp;
    assign NEXT_FETCH_POINTER   = s_q.pc;
    assign PROCESSOR_STATE_WORD = s_q.processor_state_word;
    assign STACK_TOP_POINTER    = s_q.sp;
    assign STACK_ADDR           = s_q.stk_addr;
    assign MEMORY_SIZE_SELECT   = s_q.memory_size_select;
    assign VEC_RD               = s_q.vec_rd;
    assign VEC_ADDR             = s_q.vec_addr;
    assign CORE_RUN             = s_q.st[0];  // one-hot run bit, straight from a flop
    assign MEM_REGION           = s_q.region;
    assign FETCH_FAULT          = s_q.fetch_fault;
    assign IRQ_ALLOW            = s_q.irq_allow;

    // ********************************************
    // checks
    // ********************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    vec_order_a: assert property (s_q.st == ST_VLO |=> VEC_ADDR[0] && VEC_RD)
        else $error("vector high byte not read at odd address");
    pc_vector_a: assert property (s_q.st == ST_VLO |-> ##2 (s_q.st == ST_VEND)
                                  ##1 (s_q.pc == {$past(VEC_DATA), $past(VEC_DATA, 2)}))
        else $error("fetch pointer not loaded from vector bytes");
    pc_advance_a: assert property (CORE_RUN && FETCH_ADV && !BRANCH && !IRQ_ACK &&
                                   !(!s_q.awrdy && !s_q.wrdy && !s_q.bvalid)
                                   |=> s_q.pc == $past(s_q.pc) + {14'h0000, $past(FETCH_LEN)})
        else $error("fetch pointer did not advance by length");
    gate_clear_a: assert property (CORE_RUN && IRQ_ACK |=> !s_q.processor_state_word[PSW_GATE] ##1 1'b1)
        else $error("acknowledge left interrupt gate set");
    gate_block_a: assert property (!s_d.processor_state_word[PSW_GATE] |=> !IRQ_ALLOW)
        else $error("interrupt allowed with gate clear");
    level_block_a: assert property (!s_d.processor_state_word[PSW_LEVEL] && IRQ_LOW_LEVEL |=> !IRQ_ALLOW)
        else $error("low-level request allowed while level flag clear");
    push_predec_a: assert property (CORE_RUN && STACK_PUSH |=>
                                    STACK_ADDR == s_q.sp && s_q.sp == $past(s_q.sp) - 16'h0001)
        else $error("stack write not pre-decremented");
    ram_nofetch_a: assert property (MEM_FETCH && MEM_ADDR >= RAM_FIRST && MEM_ADDR <= RAM_LAST
                                    |=> FETCH_FAULT && MEM_REGION != RG_SFR)
        else $error("fetch from RAM not flagged");
    sfr_decode_a: assert property (MEM_ADDR >= SFR_FIRST |=> MEM_REGION == RG_SFR)
        else $error("peripheral area not decoded");
    zero_flag_a: assert property (CORE_RUN && ALU_WE && !STATE_RESTORE && ALU_A == ALU_B && ALU_SUB
                                  |=> s_q.processor_state_word[PSW_ZERO] && !s_q.processor_state_word[PSW_CARRY] == !$past(CARRY_WE && CARRY_IN))
        else $error("zero flag not set on zero result");
endmodule : cpu_ctl_regs
`default_nettype wire

//--- core/cpu_ctl_pkg.sv
`default_nettype none
package cpu_ctl_pkg;
    // ********************************************
    // register offsets on the bus (byte addresses)
    // ********************************************
    localparam logic [7:0] OFS_FETCH_PTR  = 8'h00;
    localparam logic [7:0] OFS_STATE_WORD = 8'h04;
    localparam logic [7:0] OFS_STACK_PTR  = 8'h08;
    localparam logic [7:0] OFS_MEM_SIZE   = 8'h0c;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    // ********************************************
    // reset values and size select codes
    // ********************************************
    localparam logic [7:0]  RST_STATE_WORD = 8'h02;
    localparam logic [7:0]  RST_MEM_SIZE   = 8'hcf;
    localparam logic [15:0] RST_STACK_PTR  = 16'h0000;
    localparam logic [7:0]  MEM_SIZE_8K    = 8'h02;
    localparam logic [7:0]  MEM_SIZE_16K   = 8'h04;

    // ********************************************
    // state word bit positions
    // ********************************************
    localparam int PSW_CARRY = 0;
    localparam int PSW_LEVEL = 1;
    localparam int PSW_BANK0 = 3;
    localparam int PSW_NIBBL = 4;
    localparam int PSW_BANK1 = 5;
    localparam int PSW_ZERO  = 6;
    localparam int PSW_GATE  = 7;

    // ********************************************
    // memory map
    // ********************************************
    localparam logic [15:0] VEC_RESET    = 16'h0000;
    localparam logic [15:0] VEC_LOW_VOLT = 16'h0004;
    localparam logic [15:0] VEC_EXT0     = 16'h0006;
    localparam logic [15:0] VEC_CONV     = 16'h003c;
    localparam logic [15:0] VEC_LAST     = 16'h003f;
    localparam logic [15:0] TCALL_FIRST  = 16'h0040;
    localparam logic [15:0] TCALL_LAST   = 16'h007f;
    localparam logic [15:0] OPT_BYTE     = 16'h0080;
    localparam logic [15:0] SCALL_FIRST  = 16'h0800;
    localparam logic [15:0] SCALL_LAST   = 16'h0fff;
    localparam logic [15:0] ROM_LAST_8K  = 16'h1fff;
    localparam logic [15:0] ROM_LAST_16K = 16'h3fff;
    localparam logic [15:0] RAM_FIRST    = 16'hfc00;
    localparam logic [15:0] BANK_FIRST   = 16'hfee0;
    localparam logic [15:0] RAM_LAST     = 16'hfeff;
    localparam logic [15:0] SFR_FIRST    = 16'hff00;

    // region codes
    localparam logic [3:0] RG_NONE   = 4'h0;
    localparam logic [3:0] RG_VECTOR = 4'h1;
    localparam logic [3:0] RG_TCALL  = 4'h2;
    localparam logic [3:0] RG_OPTION = 4'h3;
    localparam logic [3:0] RG_ROM    = 4'h4;
    localparam logic [3:0] RG_SCALL  = 4'h5;
    localparam logic [3:0] RG_RAM    = 4'h6;
    localparam logic [3:0] RG_BANKS  = 4'h7;
    localparam logic [3:0] RG_SFR    = 4'h8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // vector fetch sequencer
    typedef enum logic [3:0] {
        ST_RUN  = 4'b0001,
        ST_VLO  = 4'b0010,
        ST_VHI  = 4'b0100,
        ST_VEND = 4'b1000
    } vstate_t;
endpackage : cpu_ctl_pkg
`default_nettype wire

//--- core/map_decode.sv
`default_nettype none
module map_decode
    import cpu_ctl_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  mem_size,
    output logic      [3:0]  region
);
    // ********************************************
    // flat 64 KB map classification
    // ********************************************
    logic [15:0] rom_last;

    // size select steers the top of flash; the reset value keeps the small part
    always_comb begin
        rom_last = (mem_size == MEM_SIZE_16K) ? ROM_LAST_16K : ROM_LAST_8K;
        if (addr >= SFR_FIRST) begin
            region = RG_SFR;
        end else if (addr >= BANK_FIRST && addr <= RAM_LAST) begin
            region = RG_BANKS;
        end else if (addr >= RAM_FIRST && addr <= RAM_LAST) begin
            region = RG_RAM;
        end else if (addr <= VEC_LAST) begin
            region = RG_VECTOR;
        end else if (addr <= TCALL_LAST) begin
            region = RG_TCALL;
        end else if (addr == OPT_BYTE) begin
            region = RG_OPTION;
        end else if (addr >= SCALL_FIRST && addr <= SCALL_LAST) begin
            region = RG_SCALL;
        end else if (addr <= rom_last) begin
            region = RG_ROM;
        end else begin
            region = RG_NONE;
        end
    end
endmodule : map_decode
`default_nettype wire

//--- testbench/vec_rom_model.sv
`default_nettype none
// ****************
// vector rom model
// ****************
module vec_rom_model (
    input  wire logic        clk,
    input  wire logic        rd,
    input  wire logic [15:0] addr,
    output logic      [7:0]  data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial data = 8'h00;
    always @(posedge clk) begin
        if (rd && addr[15:6] == '0)
            data <= addr[0] ? {3'b101, addr[5:1]} : {2'b11, addr[5:0]};
        else
            data <= ~data; // no stale byte when idle
    end
endmodule : vec_rom_model
`default_nettype wire

//--- testbench/cpu_ctl_regs_memmap_bench.sv
`default_nettype none
module cpu_ctl_regs_memmap_bench
    import cpu_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = '0, rst_n = '0, awv = '0, wv = '0, bry = '0, arv = '0, rry = '0;
    logic        fadv = '0, brn = '0, ack = '0, low = '0, ien = '0, idis = '0, awe = '0;
    logic        asub = '0, cwe = '0, cin = '0, bsel = '0, rse = '0, push = '0, pop = '0;
    logic        mf = '0, awr, wrr, bv, arr, rv, run, vrd, flt, alw;
    logic [1:0]  flen = '0, bs = '0, br, rr;
    logic [5:0]  iv = '0;
    logic [7:0]  awa = '0, ara = '0, aa = '0, ab = '0, rsd = '0, vdat, processor_state_word, msz;
    logic [15:0] bt = '0, ma = '0, pc, sp, sa, va;
    logic [31:0] wd = '0, rd;
    logic [3:0]  rg;
    int          num_errors = 0, tests_run = 0;
    always #4 mclk = ~mclk;
    cpu_ctl_regs uut (
        .MCLK(mclk), .RESET_N(rst_n), .S_AWADDR(awa), .S_AWVALID(awv), .S_AWREADY(awr),
        .S_WDATA(wd), .S_WSTRB(4'hf), .S_WVALID(wv), .S_WREADY(wrr), .S_BRESP(br),
        .S_BVALID(bv), .S_BREADY(bry), .S_ARADDR(ara), .S_ARVALID(arv), .S_ARREADY(arr),
        .S_RDATA(rd), .S_RRESP(rr), .S_RVALID(rv), .S_RREADY(rry), .FETCH_ADV(fadv),
        .FETCH_LEN(flen), .BRANCH(brn), .BRANCH_TARGET(bt), .IRQ_ACK(ack), .IRQ_VECTOR(iv),
        .IRQ_LOW_LEVEL(low), .IRQ_ENABLE_INSTR(ien), .IRQ_DISABLE_INSTR(idis), .ALU_WE(awe),
        .ALU_SUB(asub), .ALU_A(aa), .ALU_B(ab), .CARRY_WE(cwe), .CARRY_IN(cin),
        .BANK_SELECT_INSTR(bsel), .BANK_SELECT(bs), .STATE_RESTORE(rse),
        .STATE_RESTORE_DATA(rsd), .STACK_PUSH(push), .STACK_POP(pop), .MEM_ADDR(ma),
        .MEM_FETCH(mf), .VEC_DATA(vdat), .NEXT_FETCH_POINTER(pc), .PROCESSOR_STATE_WORD(processor_state_word),
        .STACK_TOP_POINTER(sp), .STACK_ADDR(sa), .MEMORY_SIZE_SELECT(msz), .VEC_RD(vrd),
        .VEC_ADDR(va), .CORE_RUN(run), .MEM_REGION(rg), .FETCH_FAULT(flt), .IRQ_ALLOW(alw));
    vec_rom_model rom (.clk(mclk), .rd(vrd), .addr(va), .data(vdat));
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge mclk);
        {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
        do begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        chk(br, er);
    endtask : wr
    task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        {ara, arv, rry} <= {a, 2'b11};
        do begin
            @(posedge mclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        chk(rd, ed);
        chk(rr, er);
    endtask : rdr
    // end a one-cycle core event and let its edge land
    task automatic fin;
        @(posedge mclk);
        {fadv, brn, ack, ien, idis, awe, cwe, bsel, rse, push, pop} <= '0;
        #1;
    endtask : fin
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        repeat (3) @(posedge mclk);
        #1;
        chk({run, pc}, {1'b1, 16'ha0c0});
        rdr(OFS_STATE_WORD, 32'h02, RESP_OKAY);
        rdr(OFS_MEM_SIZE, 32'hcf, RESP_OKAY);
        wr(OFS_MEM_SIZE, 32'h04, RESP_OKAY);
        chk(msz, 8'h04);
        rdr(8'h14, 32'h0, RESP_SLVERR);
        rdr(OFS_STATUS, 32'h02, RESP_OKAY);
    endtask : t_reset
    task automatic t_map;
        logic [15:0] ad [12] = '{16'h003f, 16'h0040, 16'h007f, 16'h0080, 16'h0fff, 16'h3fff,
            16'h4000, 16'hfc00, 16'hfedf, 16'hfee0, 16'hfeff, 16'hff00};
        logic [3:0] ex [12] = '{RG_VECTOR, RG_TCALL, RG_TCALL, RG_OPTION, RG_SCALL, RG_ROM,
            RG_NONE, RG_RAM, RG_RAM, RG_BANKS, RG_BANKS, RG_SFR};
        foreach (ad[i]) begin
            @(posedge mclk);
            {ma, mf} <= {ad[i], 1'b1};
            @(posedge mclk);
            #1;
            chk(rg, ex[i]);
            chk(flt, ad[i] inside {[16'hfc00:16'hfeff]});
        end
    endtask : t_map
    task automatic t_core;
        logic [19:0] tv [5] = '{{1'b0, 8'h0f, 8'h01, 3'b010}, {1'b0, 8'hff, 8'h01, 3'b111},
            {1'b1, 8'h10, 8'h01, 3'b010}, {1'b1, 8'h00, 8'h01, 3'b011},
            {1'b1, 8'h05, 8'h05, 3'b100}};
        @(posedge mclk);
        {brn, bt, fadv, flen} <= {17'h11000, 3'b111};
        fin;
        chk(pc, 16'h1000);
        {fadv, flen} <= 3'b111;
        fin;
        chk(pc, 16'h1003);
        foreach (tv[i]) begin
            {asub, aa, ab, awe} <= {tv[i][19:3], 1'b1};
            fin;
            chk({processor_state_word[PSW_ZERO], processor_state_word[PSW_NIBBL], processor_state_word[PSW_CARRY]}, tv[i][2:0]);
        end
        {bsel, bs, cwe, cin} <= 5'b11011;
        fin;
        chk({processor_state_word[PSW_BANK1], processor_state_word[PSW_BANK0], processor_state_word[PSW_CARRY]}, 3'b101);
        wr(OFS_STACK_PTR, 32'hfee0, RESP_OKAY);
        push <= 1'b1;
        fin;
        chk({sp, sa}, 32'hfedffedf);
        pop <= 1'b1;
        fin;
        chk({sp, sa}, 32'hfee0fedf);
        wr(OFS_STACK_PTR, 32'h1000, RESP_SLVERR);
    endtask : t_core
    task automatic t_gate;
        {ien, low} <= 2'b11;
        fin;
        @(posedge mclk);
        #1;
        chk({processor_state_word[PSW_GATE], alw}, 2'b11);
        {rse, rsd} <= {1'b1, 8'h80};
        fin;
        @(posedge mclk);
        #1;
        chk(alw, 1'b0);
        {idis, low} <= 2'b10;
        fin;
        @(posedge mclk);
        #1;
        chk({processor_state_word[PSW_GATE], alw}, 2'b00);
        {ien, ack, iv} <= {2'b11, 6'd6};
        fin;
        chk(processor_state_word[PSW_GATE], 1'b0);
        repeat (3) @(posedge mclk);
        #1;
        chk(pc, 16'ha3c6);
    endtask : t_gate
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_map;
        t_core;
        t_gate;
        test_done;
    end
    // run needs well under a thousand cycles
    initial begin
        #100000;
        num_errors++;
        test_done;
    end
endmodule : cpu_ctl_regs_memmap_bench
`default_nettype wire
